// ==== src/tos_supervisor.sv ====
`timescale 1ns/1ps
// Overview of operation
// - all four level decisions come only from the sampled thermal capacity
// - alarm 1 output only when enabled; enable resets to disabled
// - alarm 1 rises at its level, 0.1 % steps, default 40 %
// - alarm 2 output only when enabled; enable resets to disabled
// - alarm 2 rises at its own level, 0.1 % steps, default 40 %
// - restart inhibit output only when enabled; enable resets to disabled
// - restart inhibit rises at its level, default 80 %
// - trip waits an added delay in 5 ms steps, default none
// - blocking input sampled at each program cycle before pick-up checks
// - pick-up without blocking gives start and begins trip timing
// - pick-up with blocking gives blocked indication, nothing more
// - blocking after start drops start and releases like pick-up loss
// - logical node mode reported: on, blocked, test, test-blocked, off
// - condition normal, alarms, inhibit, trip or blocked; normal drives nothing
// - light load reported below 1 % of nominal current
// - overload between pick-up and 2 x In, normal below pick-up
// - bad service factor flags fault and uses 1.0
// - bad ambient settings flag fault and use correction 1.0
// - bad nominal current scaling flags fault and uses 1.0
// - inconsistent ambient factors flag own fault; flags live only while faulty
// - resettable counts of trip, alarm 1, alarm 2, inhibit and blocked
module tos_supervisor
  import tos_pkg::*;
#(
  parameter int TRIP_STEP_CYC = TRIP_STEP_CYCLES,
  parameter int CNT_W = 16
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cycle_strobe_i,
  input wire logic [VAL_W-1:0] thermal_cap_i,
  input wire logic [VAL_W-1:0] current_i,
  input wire logic blocking_i,
  output logic alarm1_o,
  output logic alarm2_o,
  output logic inhibit_o,
  output logic trip_o,
  output logic start_o,
  output logic blocked_o,
  output logic [2:0] condition_o,
  output logic [1:0] load_status_o,
  output logic [2:0] ln_mode_o,
  output logic sf_fault_o,
  output logic amb_fault_o,
  output logic nom_fault_o,
  output logic ambk_incons_o,
  output logic [VAL_W-1:0] sf_used_o,
  output logic [VAL_W-1:0] kmax_used_o,
  output logic [VAL_W-1:0] kmin_used_o,
  output logic [VAL_W-1:0] nom_used_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [2:0] en_ff;
  tos_mode_e mode_ff;
  logic [VAL_W-1:0] a1_lvl_ff;
  logic [VAL_W-1:0] a2_lvl_ff;
  logic [VAL_W-1:0] inh_lvl_ff;
  logic [VAL_W-1:0] trip_lvl_ff;
  logic [DLY_W-1:0] trip_dly_ff;
  logic [VAL_W-1:0] pickup_ff;
  logic [VAL_W-1:0] sf_ff;
  logic [VAL_W-1:0] kmax_ff;
  logic [VAL_W-1:0] kmin_ff;
  logic [VAL_W-1:0] nom_ff;
  logic [VAL_W-1:0] tcap_ff;
  logic [VAL_W-1:0] curr_ff;
  logic blk_ff;
  tos_state_e state_ff;
  tos_state_e nxt_state;
  logic [31:0] div_ff;
  logic [DLY_W-1:0] step_ff;
  logic [4:0] clr_ff;
  logic wr_en;
  logic [7:0] adr;
  logic [31:0] rd_mux;
  logic blk_now;
  logic func_off;
  logic a1_hit;
  logic a2_hit;
  logic inh_hit;
  logic pick_up;
  logic delay_done;
  logic [CNT_W-1:0] cnt_a1;
  logic [CNT_W-1:0] cnt_a2;
  logic [CNT_W-1:0] cnt_inh;
  logic [CNT_W-1:0] cnt_trip;
  logic [CNT_W-1:0] cnt_blk;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction : wb_merge

  // factor outside 0.01 .. 5.00 is unusable
  function automatic logic bad_factor(input logic [VAL_W-1:0] f);
    return (f == '0) || (f > FACTOR_MAX);
  endfunction : bad_factor

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;

  // one wait state, ack drops the cycle after it is given
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
  end

  // read data captured with the ack
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      rdat_ff <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff)
      rdat_ff <= rd_mux;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // read multiplexer, unmapped reads give zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (adr)
      ADR_CTRL: rd_mux = 32'({mode_ff, 1'b0, en_ff});
      ADR_A1_LVL: rd_mux = 32'(a1_lvl_ff);
      ADR_A2_LVL: rd_mux = 32'(a2_lvl_ff);
      ADR_INH_LVL: rd_mux = 32'(inh_lvl_ff);
      ADR_TRIP_LVL: rd_mux = 32'(trip_lvl_ff);
      ADR_TRIP_DLY: rd_mux = 32'(trip_dly_ff);
      ADR_PICKUP: rd_mux = 32'(pickup_ff);
      ADR_SF: rd_mux = 32'(sf_ff);
      ADR_KMAX: rd_mux = 32'(kmax_ff);
      ADR_KMIN: rd_mux = 32'(kmin_ff);
      ADR_NOM: rd_mux = 32'(nom_ff);
      ADR_STATUS: rd_mux = {8'h00, trip_o, inhibit_o, alarm2_o, alarm1_o, 2'b00, blocked_o, start_o,
                            ambk_incons_o, nom_fault_o, amb_fault_o, sf_fault_o, 1'b0, ln_mode_o,
                            2'b00, load_status_o, 1'b0, condition_o};
      ADR_CNT_A1: rd_mux = 32'(cnt_a1);
      ADR_CNT_A2: rd_mux = 32'(cnt_a2);
      ADR_CNT_INH: rd_mux = 32'(cnt_inh);
      ADR_CNT_TRIP: rd_mux = 32'(cnt_trip);
      ADR_CNT_BLK: rd_mux = 32'(cnt_blk);
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // setting registers
  // ---------------------------------------------------------------
  // enables and mode; an illegal mode code is stored as off
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      en_ff <= 3'b000;
      mode_ff <= MODE_ON;
    end
    else if (wr_en && adr == ADR_CTRL && wb_sel_i[0])
    begin
      en_ff <= wb_dat_i[CTRL_INH_EN:CTRL_A1_EN];
      if (wb_dat_i[CTRL_MODE_LSB +: 3] > MODE_OFF)
        mode_ff <= MODE_OFF;
      else
        mode_ff <= tos_mode_e'(wb_dat_i[CTRL_MODE_LSB +: 3]);
    end
  end

  // level thresholds in 0.1 % units
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      a1_lvl_ff <= RST_A1_LVL;
      a2_lvl_ff <= RST_A2_LVL;
      inh_lvl_ff <= RST_INH_LVL;
      trip_lvl_ff <= RST_TRIP_LVL;
    end
    else if (wr_en)
    begin
      if (adr == ADR_A1_LVL)
        a1_lvl_ff <= VAL_W'(wb_merge(32'(a1_lvl_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_A2_LVL)
        a2_lvl_ff <= VAL_W'(wb_merge(32'(a2_lvl_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_INH_LVL)
        inh_lvl_ff <= VAL_W'(wb_merge(32'(inh_lvl_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_TRIP_LVL)
        trip_lvl_ff <= VAL_W'(wb_merge(32'(trip_lvl_ff), wb_dat_i, wb_sel_i));
    end
  end

  // trip delay, pick-up limit and scaling factors
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      trip_dly_ff <= RST_TRIP_DLY;
      pickup_ff <= RST_PICKUP;
      sf_ff <= UNITY;
      kmax_ff <= UNITY;
      kmin_ff <= UNITY;
      nom_ff <= UNITY;
    end
    else if (wr_en)
    begin
      if (adr == ADR_TRIP_DLY)
        trip_dly_ff <= DLY_W'(wb_merge(32'(trip_dly_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_PICKUP)
        pickup_ff <= VAL_W'(wb_merge(32'(pickup_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_SF)
        sf_ff <= VAL_W'(wb_merge(32'(sf_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_KMAX)
        kmax_ff <= VAL_W'(wb_merge(32'(kmax_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_KMIN)
        kmin_ff <= VAL_W'(wb_merge(32'(kmin_ff), wb_dat_i, wb_sel_i));
      if (adr == ADR_NOM)
        nom_ff <= VAL_W'(wb_merge(32'(nom_ff), wb_dat_i, wb_sel_i));
    end
  end

  // counter clear pulses, one cycle per write
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      clr_ff <= 5'h00;
    else if (wr_en && adr == ADR_CNT_CLR && wb_sel_i[0])
      clr_ff <= wb_dat_i[4:0];
    else
      clr_ff <= 5'h00;
  end

  // ---------------------------------------------------------------
  // program cycle sampling
  // ---------------------------------------------------------------
  assign func_off = (mode_ff == MODE_OFF);
  // block from the matrix input or from a blocked mode
  assign blk_now = blocking_i || mode_ff == MODE_BLOCKED || mode_ff == MODE_TEST_BLOCKED;

  // blocking, capacity and current latched first in each cycle
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      blk_ff <= 1'b0;
      tcap_ff <= '0;
      curr_ff <= '0;
    end
    else if (cycle_strobe_i)
    begin
      blk_ff <= blk_now;
      tcap_ff <= thermal_cap_i;
      curr_ff <= current_i;
    end
  end

  // ---------------------------------------------------------------
  // level decisions
  // ---------------------------------------------------------------
  tos_level_cmp #(.W(VAL_W)) u_cmp_a1 (
    .value_i(tcap_ff),
    .level_i(a1_lvl_ff),
    .enable_i(en_ff[CTRL_A1_EN] && !func_off),
    .active_o(a1_hit)
  );

  tos_level_cmp #(.W(VAL_W)) u_cmp_a2 (
    .value_i(tcap_ff),
    .level_i(a2_lvl_ff),
    .enable_i(en_ff[CTRL_A2_EN] && !func_off),
    .active_o(a2_hit)
  );

  tos_level_cmp #(.W(VAL_W)) u_cmp_inh (
    .value_i(tcap_ff),
    .level_i(inh_lvl_ff),
    .enable_i(en_ff[CTRL_INH_EN] && !func_off),
    .active_o(inh_hit)
  );

  tos_level_cmp #(.W(VAL_W)) u_cmp_trip (
    .value_i(tcap_ff),
    .level_i(trip_lvl_ff),
    .enable_i(!func_off),
    .active_o(pick_up)
  );

  // alarm and inhibit outputs follow their compares
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      alarm1_o <= 1'b0;
      alarm2_o <= 1'b0;
      inhibit_o <= 1'b0;
    end
    else
    begin
      alarm1_o <= a1_hit;
      alarm2_o <= a2_hit;
      inhibit_o <= inh_hit;
    end
  end

  // ---------------------------------------------------------------
  // start, blocked and trip sequence
  // ---------------------------------------------------------------
  assign delay_done = (step_ff >= trip_dly_ff);

  // pick-up judged only at a program cycle with fresh blocking
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if (cycle_strobe_i && pick_up && !blk_now)
          nxt_state = ST_TIMING;
        else if (cycle_strobe_i && pick_up && blk_now)
          nxt_state = ST_BLOCKED;
      ST_TIMING:
        if (cycle_strobe_i && (!pick_up || blk_now))
          nxt_state = ST_IDLE;
        else if (delay_done)
          nxt_state = ST_TRIP;
      ST_TRIP:
        if (cycle_strobe_i && (!pick_up || blk_now))
          nxt_state = ST_IDLE;
      ST_BLOCKED:
        if (cycle_strobe_i && (!pick_up || !blk_now))
          nxt_state = ST_IDLE;
    endcase
    if (func_off)
      nxt_state = ST_IDLE;
  end

  // sequence state register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // 5 ms step timer, runs only while timing a start
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || state_ff != ST_TIMING)
    begin
      div_ff <= 32'h00000000;
      step_ff <= '0;
    end
    else if (div_ff == 32'(TRIP_STEP_CYC - 1))
    begin
      div_ff <= 32'h00000000;
      if (step_ff != '1)
        step_ff <= step_ff + DLY_W'(1);
    end
    else
      div_ff <= div_ff + 32'h00000001;
  end

  // sequence indications
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      start_o <= 1'b0;
      blocked_o <= 1'b0;
      trip_o <= 1'b0;
    end
    else
    begin
      start_o <= (nxt_state == ST_TIMING) || (nxt_state == ST_TRIP);
      blocked_o <= (nxt_state == ST_BLOCKED);
      trip_o <= (nxt_state == ST_TRIP);
    end
  end

  // ---------------------------------------------------------------
  // condition, load and mode reporting
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      condition_o <= COND_NORMAL;
    else if (blocked_o)
      condition_o <= COND_BLOCKED;
    else if (trip_o)
      condition_o <= COND_TRIP;
    else if (inhibit_o)
      condition_o <= COND_INHIBIT;
    else if (alarm2_o)
      condition_o <= COND_ALARM2;
    else if (alarm1_o)
      condition_o <= COND_ALARM1;
    else
      condition_o <= COND_NORMAL;
  end

  // load status from sampled current in per-mille of nominal
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      load_status_o <= LOAD_LIGHT;
    else if (curr_ff < LIGHT_LOAD)
      load_status_o <= LOAD_LIGHT;
    else if (curr_ff < pickup_ff)
      load_status_o <= LOAD_NORMAL;
    else if (curr_ff < HIGH_LOAD)
      load_status_o <= LOAD_OVER;
    else
      load_status_o <= LOAD_HIGH;
  end

  // mode shown as stored
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      ln_mode_o <= MODE_ON;
    else
      ln_mode_o <= mode_ff;
  end

  // ---------------------------------------------------------------
  // setting supervision
  // ---------------------------------------------------------------
  // fault flags track the settings, overrides take 1.00
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sf_fault_o <= 1'b0;
      amb_fault_o <= 1'b0;
      nom_fault_o <= 1'b0;
      ambk_incons_o <= 1'b0;
      sf_used_o <= UNITY;
      kmax_used_o <= UNITY;
      kmin_used_o <= UNITY;
      nom_used_o <= UNITY;
    end
    else
    begin
      sf_fault_o <= bad_factor(sf_ff);
      sf_used_o <= bad_factor(sf_ff) ? UNITY : sf_ff;
      amb_fault_o <= bad_factor(kmax_ff) || bad_factor(kmin_ff);
      kmax_used_o <= (bad_factor(kmax_ff) || bad_factor(kmin_ff)) ? UNITY : kmax_ff;
      kmin_used_o <= (bad_factor(kmax_ff) || bad_factor(kmin_ff)) ? UNITY : kmin_ff;
      nom_fault_o <= bad_factor(nom_ff);
      nom_used_o <= bad_factor(nom_ff) ? UNITY : nom_ff;
      ambk_incons_o <= (kmin_ff < kmax_ff);
    end
  end

  // ---------------------------------------------------------------
  // activation counters
  // ---------------------------------------------------------------
  tos_event_counter #(.W(CNT_W)) u_cnt_a1 (
    .mclk_i(mclk_i), .rst_i(rst_i), .clr_i(clr_ff[0]), .evt_i(alarm1_o), .count_o(cnt_a1)
  );
  tos_event_counter #(.W(CNT_W)) u_cnt_a2 (
    .mclk_i(mclk_i), .rst_i(rst_i), .clr_i(clr_ff[1]), .evt_i(alarm2_o), .count_o(cnt_a2)
  );
  tos_event_counter #(.W(CNT_W)) u_cnt_inh (
    .mclk_i(mclk_i), .rst_i(rst_i), .clr_i(clr_ff[2]), .evt_i(inhibit_o), .count_o(cnt_inh)
  );
  tos_event_counter #(.W(CNT_W)) u_cnt_trip (
    .mclk_i(mclk_i), .rst_i(rst_i), .clr_i(clr_ff[3]), .evt_i(trip_o), .count_o(cnt_trip)
  );
  tos_event_counter #(.W(CNT_W)) u_cnt_blk (
    .mclk_i(mclk_i), .rst_i(rst_i), .clr_i(clr_ff[4]), .evt_i(blocked_o), .count_o(cnt_blk)
  );
endmodule : tos_supervisor

// ==== src/tos_pkg.sv ====
package tos_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TRIP_STEP_US = 5000; // trip delay step, 0.005 s
  localparam int TRIP_STEP_CYCLES = TRIP_STEP_US * (CLK_HZ / 1_000_000);

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VAL_W = 16; // per-mille values and hundredth factors
  localparam int DLY_W = 20; // trip delay in 5 ms steps

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_A1_LVL = 8'h04;
  localparam logic [7:0] ADR_A2_LVL = 8'h08;
  localparam logic [7:0] ADR_INH_LVL = 8'h0C;
  localparam logic [7:0] ADR_TRIP_LVL = 8'h10;
  localparam logic [7:0] ADR_TRIP_DLY = 8'h14;
  localparam logic [7:0] ADR_PICKUP = 8'h18;
  localparam logic [7:0] ADR_SF = 8'h1C;
  localparam logic [7:0] ADR_KMAX = 8'h20;
  localparam logic [7:0] ADR_KMIN = 8'h24;
  localparam logic [7:0] ADR_NOM = 8'h28;
  localparam logic [7:0] ADR_STATUS = 8'h2C;
  localparam logic [7:0] ADR_CNT_CLR = 8'h30;
  localparam logic [7:0] ADR_CNT_A1 = 8'h34;
  localparam logic [7:0] ADR_CNT_A2 = 8'h38;
  localparam logic [7:0] ADR_CNT_INH = 8'h3C;
  localparam logic [7:0] ADR_CNT_TRIP = 8'h40;
  localparam logic [7:0] ADR_CNT_BLK = 8'h44;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_A1_EN = 0;
  localparam int CTRL_A2_EN = 1;
  localparam int CTRL_INH_EN = 2;
  localparam int CTRL_MODE_LSB = 4;

  // ---------------------------------------------------------------
  // reset values and limits (per-mille or hundredths)
  // ---------------------------------------------------------------
  localparam logic [VAL_W-1:0] RST_A1_LVL = 16'h0190; // 40.0 %
  localparam logic [VAL_W-1:0] RST_A2_LVL = 16'h0190; // 40.0 %
  localparam logic [VAL_W-1:0] RST_INH_LVL = 16'h0320; // 80.0 %
  localparam logic [VAL_W-1:0] RST_TRIP_LVL = 16'h03E8; // 100.0 %
  localparam logic [DLY_W-1:0] RST_TRIP_DLY = 20'h00000;
  localparam logic [VAL_W-1:0] RST_PICKUP = 16'h041A; // 1.05 x In
  localparam logic [VAL_W-1:0] UNITY = 16'h0064; // factor 1.00
  localparam logic [VAL_W-1:0] FACTOR_MAX = 16'h01F4; // factor 5.00
  localparam logic [VAL_W-1:0] LIGHT_LOAD = 16'h000A; // 1 % of In
  localparam logic [VAL_W-1:0] HIGH_LOAD = 16'h07D0; // 2 x In

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ON = 3'b000,
    MODE_BLOCKED = 3'b001,
    MODE_TEST = 3'b010,
    MODE_TEST_BLOCKED = 3'b011,
    MODE_OFF = 3'b100
  } tos_mode_e;

  typedef enum logic [2:0] {
    COND_NORMAL = 3'b000,
    COND_ALARM1 = 3'b001,
    COND_ALARM2 = 3'b010,
    COND_INHIBIT = 3'b011,
    COND_TRIP = 3'b100,
    COND_BLOCKED = 3'b101
  } tos_cond_e;

  typedef enum logic [1:0] {
    LOAD_LIGHT = 2'b00,
    LOAD_NORMAL = 2'b01,
    LOAD_OVER = 2'b10,
    LOAD_HIGH = 2'b11
  } tos_load_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TIMING = 2'b01,
    ST_TRIP = 2'b10,
    ST_BLOCKED = 2'b11
  } tos_state_e;
endpackage : tos_pkg

// ==== src/tos_level_cmp.sv ====
`timescale 1ns/1ps
module tos_level_cmp
  import tos_pkg::*;
#(
  parameter int W = VAL_W
)
(
  input wire logic [W-1:0] value_i,
  input wire logic [W-1:0] level_i,
  input wire logic enable_i,
  output logic active_o
);
  // inclusive compare, drops as soon as value is below level
  assign active_o = enable_i && (value_i >= level_i);
endmodule : tos_level_cmp

// ==== src/tos_event_counter.sv ====
`timescale 1ns/1ps
module tos_event_counter
  import tos_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic evt_i,
  output logic [W-1:0] count_o
);
  logic prev_ff;
  logic rise;

  // rising edge of the watched signal
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      prev_ff <= 1'b0;
    else
      prev_ff <= evt_i;
  end

  assign rise = evt_i && !prev_ff;

  // saturating count, an activation beats a clear
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      count_o <= '0;
    else if (rise && clr_i)
      count_o <= W'(1);
    else if (clr_i)
      count_o <= '0;
    else if (rise && (count_o != '1))
      count_o <= count_o + W'(1);
  end
endmodule : tos_event_counter

// ==== dv/tos_blk_model.sv ====
`timescale 1ns/1ps
module tos_blk_model
(
  input wire logic mclk_i,
  input wire logic blk_req_i,
  output logic blocking_o
);
  // blocking level, follows the request one clock later
  always_ff @(posedge mclk_i)
  begin
    blocking_o <= blk_req_i;
  end
endmodule : tos_blk_model

// ==== dv/tos_supervisor_monitor.sv ====
`timescale 1ns/1ps
module tos_chk
  import tos_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cycle_strobe_i,
  input wire logic [VAL_W-1:0] current_i,
  input wire logic blocking_i,
  input wire logic alarm1_o,
  input wire logic trip_o,
  input wire logic start_o,
  input wire logic blocked_o,
  input wire logic [2:0] condition_o,
  input wire logic [1:0] load_status_o,
  input wire logic sf_fault_o,
  input wire logic nom_fault_o,
  input wire logic [VAL_W-1:0] sf_used_o,
  input wire logic [VAL_W-1:0] nom_used_o
);
  // shared clock and reset
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_norm;
    $rose(alarm1_o) |=> condition_o != COND_NORMAL;
  endproperty
  a_norm: assert property (p_norm) else $error("alarm as normal");
  property p_tcond;
    trip_o |=> condition_o inside {COND_TRIP, COND_BLOCKED};
  endproperty
  a_tcond: assert property (p_tcond) else $error("trip condition");
  property p_excl;
    blocked_o |-> !start_o;
  endproperty
  a_excl: assert property (p_excl) else $error("start while blocked");
  property p_drop;
    cycle_strobe_i && blocking_i && start_o |=> !start_o && !trip_o;
  endproperty
  a_drop: assert property (p_drop) else $error("start kept");
  property p_tstart;
    $rose(trip_o) |-> $past(start_o);
  endproperty
  a_tstart: assert property (p_tstart) else $error("trip without start");
  property p_light;
    cycle_strobe_i && current_i < LIGHT_LOAD |-> ##2 load_status_o == LOAD_LIGHT;
  endproperty
  a_light: assert property (p_light) else $error("light load");
  property p_sf;
    sf_fault_o |-> sf_used_o == UNITY;
  endproperty
  a_sf: assert property (p_sf) else $error("factor override");
  property p_nom;
    nom_fault_o |-> nom_used_o == UNITY;
  endproperty
  a_nom: assert property (p_nom) else $error("nominal override");
endmodule : tos_chk
bind tos_supervisor tos_chk u_chk (.*);

// ==== dv/tos_supervisor_tb.sv ====
`timescale 1ns/1ps
module tos_supervisor_tb
  import tos_pkg::*;
;
  logic mclk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, blk_req = 1'b0;
  logic cycle_strobe_i = 1'b0, wb_ack_o, blocking_i, alarm1_o, alarm2_o, inhibit_o, trip_o, start_o;
  logic blocked_o, sf_fault_o, amb_fault_o, nom_fault_o, ambk_incons_o;
  logic [1:0] load_status_o;
  logic [2:0] condition_o, ln_mode_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [15:0] thermal_cap_i = 16'h0, current_i = 16'h0, sf_used_o, kmax_used_o, kmin_used_o, nom_used_o;
  int bad_count = 0, cmp_count = 0, tick = 0, i;
  // device with a short trip step
  tos_supervisor #(.TRIP_STEP_CYC(4)) uut (.*);
  tos_blk_model blk (.mclk_i(mclk_i), .blk_req_i(blk_req), .blocking_o(blocking_i));
  // clock and hang guard
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
    if (++tick == 3000) give_verdict(1);
  // verdict
  task give_verdict(input int extra);
    bad_count += extra;
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one classic bus cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge mclk_i);
    while (wb_ack_o !== 1'b1) @(posedge mclk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // program cycles with fixed inputs
  task strobe(input logic [15:0] c, input logic [15:0] cur, input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      cycle_strobe_i <= 1'b1;
      thermal_cap_i <= c;
      current_i <= cur;
      @(posedge mclk_i);
      cycle_strobe_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask : strobe
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(ADR_CTRL, 32'h0);
    rd(ADR_A1_LVL, {16'h0, RST_A1_LVL});
    rd(ADR_A2_LVL, {16'h0, RST_A2_LVL});
    rd(ADR_INH_LVL, {16'h0, RST_INH_LVL});
    rd(ADR_TRIP_DLY, {12'h0, RST_TRIP_DLY});
    rd(8'hFC, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1);
    strobe(16'h0190, 16'h0064, 2);
    chk({alarm1_o, alarm2_o, inhibit_o}, 32'h4);
    strobe(16'h018F, 16'h0064, 2);
    chk(alarm1_o, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h7);
    wb(1'b1, ADR_A2_LVL, 32'h1F4);
    strobe(16'h01F4, 16'h0064, 2);
    chk({alarm1_o, alarm2_o, inhibit_o, condition_o}, {3'h6, COND_ALARM2});
    strobe(16'h0320, 16'h0064, 2);
    chk({alarm1_o, alarm2_o, inhibit_o, condition_o}, {3'h7, COND_INHIBIT});
    wb(1'b1, ADR_TRIP_DLY, 32'h2);
    strobe(16'h03E8, 16'h0064, 2);
    chk({start_o, trip_o}, 32'h2);
    repeat (10) @(posedge mclk_i);
    chk({start_o, trip_o, condition_o}, {2'h3, COND_TRIP});
    blk_req <= 1'b1;
    strobe(16'h03E8, 16'h0064, 1);
    chk({start_o, trip_o, blocked_o}, 32'h0);
    strobe(16'h03E8, 16'h0064, 1);
    chk({start_o, blocked_o, condition_o}, {2'h1, COND_BLOCKED});
    rd(ADR_CNT_A1, 32'h2);
    rd(ADR_CNT_TRIP, 32'h1);
    rd(ADR_CNT_BLK, 32'h1);
    rd(ADR_CNT_INH, 32'h1);
    wb(1'b1, ADR_CNT_CLR, 32'h1F);
    rd(ADR_CNT_TRIP, 32'h0);
    blk_req <= 1'b0;
    strobe(16'h0000, 16'h0005, 1);
    chk(load_status_o, LOAD_LIGHT);
    strobe(16'h0000, 16'h05DC, 1);
    chk(load_status_o, LOAD_OVER);
    strobe(16'h0000, 16'h09C4, 1);
    chk(load_status_o, LOAD_HIGH);
    strobe(16'h0000, 16'h0064, 1);
    chk(load_status_o, LOAD_NORMAL);
    wb(1'b1, ADR_SF, 32'h0);
    wb(1'b1, ADR_KMAX, 32'h0);
    wb(1'b1, ADR_NOM, 32'h258);
    strobe(16'h0000, 16'h0064, 1);
    chk({sf_fault_o, sf_used_o}, {1'b1, UNITY});
    chk({amb_fault_o, kmax_used_o}, {1'b1, UNITY});
    chk(kmin_used_o, UNITY);
    chk({nom_fault_o, nom_used_o}, {1'b1, UNITY});
    wb(1'b1, ADR_SF, 32'hC8);
    wb(1'b1, ADR_KMAX, 32'h96);
    strobe(16'h0000, 16'h0064, 1);
    chk({sf_fault_o, sf_used_o, amb_fault_o, ambk_incons_o}, {1'b0, 16'h00C8, 2'h1});
    for (i = 0; i < 5; i++)
    begin
      wb(1'b1, ADR_CTRL, 32'h7 | (i << 4));
      strobe(16'h03E8, 16'h0064, 2);
      chk(ln_mode_o, i[2:0]);
    end
    chk({alarm1_o, alarm2_o, inhibit_o, trip_o, start_o, condition_o}, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h70);
    rd(ADR_CTRL, 32'h40);
    give_verdict(0);
  end
endmodule : tos_supervisor_tb
